// ===== design/pkrp_pkg.sv
// package of constants and types for the power key and reset pin block
`default_nettype none
package pkrp_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int unsigned DEBOUNCE_MS   = 16;
  localparam int unsigned KEY_BASE_MS   = 1000;
  localparam int unsigned RST_DELAY0_MS = 3;
  localparam int unsigned RST_DELAY1_MS = 11;
  localparam int unsigned RST_DELAY2_MS = 51;
  localparam int unsigned RST_DELAY3_MS = 101;
  localparam int unsigned HOLD_W        = 14;
  localparam int unsigned DELAY_W       = 7;

  localparam logic [15:0] IDX_KEY_CTRL  = 16'h4005;
  localparam logic [15:0] IDX_RST_CTRL  = 16'h4006;
  localparam logic [15:0] IDX_SECURITY  = 16'h4008;
  localparam logic [15:0] IDX_FLAGS_ONE = 16'h4011;
  localparam logic [15:0] IDX_CHG_CTRL  = 16'h4020;
  localparam logic [15:0] IDX_MASK_ONE  = 16'h4019;
  localparam int unsigned ADDR_W        = 18;

  localparam int unsigned KEY_HOLD_LSB  = 8;
  localparam int unsigned KEY_FIRST_LSB = 4;
  localparam int unsigned KEY_LEVEL_BIT = 3;
  localparam int unsigned KEY_TO_LSB    = 0;
  localparam int unsigned AUX_SLP_BIT   = 6;
  localparam int unsigned RIN_MSK_BIT   = 5;
  localparam int unsigned RDRV_SLP_BIT  = 4;
  localparam int unsigned RDLY_LSB      = 0;
  localparam int unsigned KEY_EVENT_BIT = 12;
  localparam int unsigned CHG_INH_BIT   = 0;

  // user key code value is arbitrary
  localparam logic [15:0] USER_KEY_CODE = 16'h5a3c;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_ON   = 2'h1;
  localparam logic [1:0] ACT_OFF  = 2'h2;

  typedef struct packed {
    logic [1:0] hold_resp;
    logic [1:0] first_resp;
    logic [1:0] hold_to;
  } pkrp_key_ctrl_t;
  localparam pkrp_key_ctrl_t KEY_CTRL_RST = '{hold_resp: 2'h1, first_resp: 2'h0, hold_to: 2'h0};

  typedef struct packed {
    logic       aux_sleep;
    logic       in_sleep_mask;
    logic       drive_sleep;
    logic [1:0] delay;
  } pkrp_rst_ctrl_t;
  localparam pkrp_rst_ctrl_t RST_CTRL_RST = '{1'b1, 1'b1, 1'b1, 2'h3};

  typedef enum logic [2:0] {
    PWR_OFF   = 3'h1,
    PWR_ON    = 3'h2,
    PWR_SLEEP = 3'h4
  } pkrp_pwr_t;

  typedef struct packed {
    logic on_req;
    logic off_req;
  } pkrp_req_t;

  typedef enum logic [3:0] {
    KS_IDLE  = 4'h1,
    KS_HOLD1 = 4'h2,
    KS_HOLD2 = 4'h4,
    KS_DONE  = 4'h8
  } pkrp_key_st_t;
endpackage
`default_nettype wire

// ===== design/pkrp_top.sv
// power key, reset pin and power state indicator logic with avalon-mm registers
// Functional notes
// - on indicator high in ON, sleep indicator high in SLEEP.
// - key pin active low, debounced before any action.
// - key press does first response: ignore, ON request, OFF request, reserved.
// - key event raised on every press and every release.
// - held past one timeout, hold response: event, ON, OFF, reserved.
// - hold timeout selects 1s, 2s, 4s or 8s; default 1s.
// - held one more timeout after hold response, always OFF request.
// - key OFF requests suppressed while charging with charge-off inhibit set.
// - read-only level flag: 0 key asserted, 1 not asserted.
// - key and reset control writes take effect only after user key unlock.
// - key event flag set on both edges, cleared by writing one.
// - key interrupt out when flag set and mask clear; mask resets to one.
// - reset pin open drain, driven low throughout OFF.
// - in SLEEP reset pin driven low when drive-in-sleep bit set.
// - after ON or WAKE completes, reset held low 3, 11, 51 or 101 ms.
// - external low on reset pin resets control registers, requests start-up.
// - in SLEEP external reset ignored when input sleep mask set.
// - aux reset asserted in OFF, and in SLEEP when aux sleep bit set.
`default_nettype none
module pkrp_top
  import pkrp_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES,
  parameter int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              key_pin_n,
  input  wire logic              reset_pin_in,
  output logic                   reset_pin_out,
  output logic                   reset_pin_oe,
  input  wire pkrp_pwr_t         pwr_state,
  input  wire logic              pwr_up_done,
  input  wire logic              charging,
  output pkrp_req_t              pwr_req,
  output logic                   hw_reset_req,
  output logic                   key_irq,
  output logic                   on_ind,
  output logic                   sleep_ind,
  output logic                   aux_reset
);
  if (MS_TICK_CYCLES < 2 || DEBOUNCE_TICKS < 1 || DEBOUNCE_TICKS > 255) begin : g_param_check
    $error("pkrp_top: unsupported tick or debounce parameter");
  end

  localparam int unsigned TICK_W = $clog2(MS_TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);
  localparam logic [7:0] DEB_LAST = 8'(DEBOUNCE_TICKS - 1);

  // ---------------- registers ----------------
  pkrp_key_ctrl_t key_ctrl_q;
  pkrp_rst_ctrl_t rst_ctrl_q;
  logic           unlocked_q;
  logic           event_flag_q;
  logic           event_mask_q;
  logic           chg_inhibit_q;
  logic           ack_q;
  logic [31:0]    rdata_q;

  // ---------------- bus decode ----------------
  wire logic [15:0] reg_idx   = avs_address[ADDR_W-1:2];
  wire logic        access    = avs_read | avs_write;
  wire logic        wr_take   = avs_write & ack_q;
  wire logic        rd_take   = avs_read & ~ack_q;
  wire logic [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [15:0] wdata     = avs_writedata[15:0];
  wire logic        hit_key   = reg_idx == IDX_KEY_CTRL;
  wire logic        hit_rst   = reg_idx == IDX_RST_CTRL;
  wire logic        hit_sec   = reg_idx == IDX_SECURITY;
  wire logic        hit_flag  = reg_idx == IDX_FLAGS_ONE;
  wire logic        hit_mask  = reg_idx == IDX_MASK_ONE;
  wire logic        hit_chg   = reg_idx == IDX_CHG_CTRL;

  // one wait cycle, then the answer
  assign avs_waitrequest = access & ~ack_q;
  assign avs_readdata    = rdata_q;

  // merge of a byte-masked write into a 16-bit image
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ---------------- millisecond tick ----------------
  logic [TICK_W-1:0] tick_cnt_q;
  wire logic         ms_tick = tick_cnt_q == TICK_LAST;

  always_ff @(posedge sys_clk) begin
    if (rst || ms_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // ---------------- key debounce ----------------
  logic       key_stable_q;
  logic       key_prev_q;
  logic [7:0] deb_cnt_q;
  wire logic  key_raw      = ~key_pin_n;
  wire logic  key_differs  = key_raw != key_stable_q;
  wire logic  deb_done     = ms_tick & key_differs & (deb_cnt_q == DEB_LAST);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      deb_cnt_q    <= '0;
      key_stable_q <= 1'b0;
    end else if (!key_differs) begin
      deb_cnt_q <= '0;
    end else if (deb_done) begin
      deb_cnt_q    <= '0;
      key_stable_q <= key_raw;
    end else if (ms_tick) begin
      deb_cnt_q <= deb_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_prev_q <= 1'b0;
    end else begin
      key_prev_q <= key_stable_q;
    end
  end

  wire logic key_press   = key_stable_q & ~key_prev_q;
  wire logic key_release = ~key_stable_q & key_prev_q;

  // ---------------- key hold sequencer ----------------
  pkrp_key_st_t      key_st_q;
  pkrp_key_st_t      key_st_d;
  logic [HOLD_W-1:0] hold_cnt_q;
  wire logic [HOLD_W-1:0] hold_limit =
    HOLD_W'(KEY_BASE_MS) << key_ctrl_q.hold_to;
  wire logic         hold_hit = ms_tick & (hold_cnt_q == hold_limit - HOLD_W'(1));
  wire logic         hold_fire = (key_st_q == KS_HOLD1) & hold_hit;
  wire logic         last_fire = (key_st_q == KS_HOLD2) & hold_hit;

  always_comb begin
    key_st_d = key_st_q;
    unique case (key_st_q)
      KS_IDLE: begin
        if (key_press) key_st_d = KS_HOLD1;
      end
      KS_HOLD1: begin
        if (!key_stable_q) key_st_d = KS_IDLE;
        else if (hold_hit) key_st_d = KS_HOLD2;
      end
      KS_HOLD2: begin
        if (!key_stable_q) key_st_d = KS_IDLE;
        else if (hold_hit) key_st_d = KS_DONE;
      end
      KS_DONE: begin
        if (!key_stable_q) key_st_d = KS_IDLE;
      end
      default: key_st_d = KS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_st_q <= KS_IDLE;
    end else begin
      key_st_q <= key_st_d;
    end
  end

  // hold counter restarts on each state change
  always_ff @(posedge sys_clk) begin
    if (rst || key_st_d != key_st_q) begin
      hold_cnt_q <= '0;
    end else if (ms_tick) begin
      hold_cnt_q <= hold_cnt_q + HOLD_W'(1);
    end
  end

  // ---------------- key actions ----------------
  wire logic first_on   = key_press & (key_ctrl_q.first_resp == ACT_ON);
  wire logic first_off  = key_press & (key_ctrl_q.first_resp == ACT_OFF);
  wire logic hold_on    = hold_fire & (key_ctrl_q.hold_resp == ACT_ON);
  wire logic hold_off   = hold_fire & (key_ctrl_q.hold_resp == ACT_OFF);
  wire logic hold_event = hold_fire & (key_ctrl_q.hold_resp == ACT_NONE);
  wire logic off_block  = charging & chg_inhibit_q;
  wire logic on_req_d   = first_on | hold_on;
  wire logic off_req_d  = (first_off | hold_off | last_fire) & ~off_block;
  wire logic key_event  = key_press | key_release | hold_event;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_req <= '0;
    end else begin
      pwr_req.on_req  <= on_req_d;
      pwr_req.off_req <= off_req_d;
    end
  end

  // ---------------- reset pin ----------------
  logic [DELAY_W-1:0] delay_cnt_q;
  logic               delay_act_q;
  logic               ext_low_q;
  logic               drive_q;
  logic               hw_req_q;
  logic [DELAY_W-1:0] delay_ms;

  always_comb begin
    unique case (rst_ctrl_q.delay)
      2'h0:    delay_ms = DELAY_W'(RST_DELAY0_MS);
      2'h1:    delay_ms = DELAY_W'(RST_DELAY1_MS);
      2'h2:    delay_ms = DELAY_W'(RST_DELAY2_MS);
      default: delay_ms = DELAY_W'(RST_DELAY3_MS);
    endcase
  end

  wire logic in_off   = pwr_state == PWR_OFF;
  wire logic in_on    = pwr_state == PWR_ON;
  wire logic in_sleep = pwr_state == PWR_SLEEP;
  wire logic delay_end = delay_act_q & ms_tick & (delay_cnt_q == delay_ms - DELAY_W'(1));
  wire logic drive_d  = in_off
                      | (in_sleep & rst_ctrl_q.drive_sleep)
                      | (pwr_up_done | (delay_act_q & ~delay_end));
  wire logic ext_low  = ~reset_pin_in & ~drive_q;
  wire logic ext_ok   = ext_low & ~(in_sleep & rst_ctrl_q.in_sleep_mask);
  wire logic hw_reset = ext_ok & ~ext_low_q;

  // delay starts when the on or wake sequence completes
  always_ff @(posedge sys_clk) begin
    if (rst || pwr_up_done) begin
      delay_cnt_q <= '0;
    end else if (delay_act_q && ms_tick) begin
      delay_cnt_q <= delay_cnt_q + DELAY_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      delay_act_q <= 1'b0;
    end else if (pwr_up_done) begin
      delay_act_q <= 1'b1;
    end else if (delay_end) begin
      delay_act_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q   <= 1'b1;
      ext_low_q <= 1'b0;
      hw_req_q  <= 1'b0;
    end else begin
      drive_q   <= drive_d;
      ext_low_q <= ext_ok;
      hw_req_q  <= hw_reset;
    end
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = drive_q;
  assign hw_reset_req  = hw_req_q;

  // ---------------- state indicators ----------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      on_ind    <= 1'b0;
      sleep_ind <= 1'b0;
      aux_reset <= 1'b1;
    end else begin
      on_ind    <= in_on;
      sleep_ind <= in_sleep;
      aux_reset <= in_off | (in_sleep & rst_ctrl_q.aux_sleep);
    end
  end

  // ---------------- register writes ----------------
  wire logic        ctl_reset = rst | hw_reset;
  wire logic [15:0] key_img =
    merge({6'h0, key_ctrl_q.hold_resp, 2'h0, key_ctrl_q.first_resp, 2'h0,
           key_ctrl_q.hold_to}, wdata, lane_mask);
  wire logic [15:0] rst_img =
    merge({9'h0, rst_ctrl_q.aux_sleep, rst_ctrl_q.in_sleep_mask,
           rst_ctrl_q.drive_sleep, 2'h0, rst_ctrl_q.delay}, wdata, lane_mask);
  wire logic [15:0] w1c     = wdata & lane_mask;
  wire logic [15:0] mask_img = merge({3'h0, event_mask_q, 12'h0}, wdata, lane_mask);
  wire logic [15:0] chg_img  = merge({15'h0, chg_inhibit_q}, wdata, lane_mask);

  always_ff @(posedge sys_clk) begin
    if (ctl_reset) begin
      key_ctrl_q <= KEY_CTRL_RST;
      rst_ctrl_q <= RST_CTRL_RST;
    end else if (wr_take && unlocked_q) begin
      if (hit_key) begin
        key_ctrl_q.hold_resp  <= key_img[KEY_HOLD_LSB +: 2];
        key_ctrl_q.first_resp <= key_img[KEY_FIRST_LSB +: 2];
        key_ctrl_q.hold_to    <= key_img[KEY_TO_LSB +: 2];
      end
      if (hit_rst) begin
        rst_ctrl_q.aux_sleep     <= rst_img[AUX_SLP_BIT];
        rst_ctrl_q.in_sleep_mask <= rst_img[RIN_MSK_BIT];
        rst_ctrl_q.drive_sleep   <= rst_img[RDRV_SLP_BIT];
        rst_ctrl_q.delay         <= rst_img[RDLY_LSB +: 2];
      end
    end
  end

  // user key: right code unlocks, any other write with both low byte lanes enabled locks again
  always_ff @(posedge sys_clk) begin
    if (ctl_reset) begin
      unlocked_q <= 1'b0;
    end else if (wr_take && hit_sec && (&avs_byteenable[1:0])) begin
      unlocked_q <= wdata == USER_KEY_CODE;
    end
  end

  // event wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (ctl_reset) begin
      event_flag_q <= 1'b0;
    end else if (key_event) begin
      event_flag_q <= 1'b1;
    end else if (wr_take && hit_flag && w1c[KEY_EVENT_BIT]) begin
      event_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ctl_reset) begin
      event_mask_q  <= 1'b1;
      chg_inhibit_q <= 1'b0;
    end else if (wr_take) begin
      if (hit_mask) event_mask_q <= mask_img[KEY_EVENT_BIT];
      if (hit_chg) chg_inhibit_q <= chg_img[CHG_INH_BIT];
    end
  end

  assign key_irq = event_flag_q & ~event_mask_q;

  // ---------------- register reads ----------------
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (hit_key) begin
      rd_val[KEY_HOLD_LSB +: 2]  = key_ctrl_q.hold_resp;
      rd_val[KEY_FIRST_LSB +: 2] = key_ctrl_q.first_resp;
      rd_val[KEY_LEVEL_BIT]      = ~key_stable_q;
      rd_val[KEY_TO_LSB +: 2]    = key_ctrl_q.hold_to;
    end
    if (hit_rst) begin
      rd_val[AUX_SLP_BIT]    = rst_ctrl_q.aux_sleep;
      rd_val[RIN_MSK_BIT]    = rst_ctrl_q.in_sleep_mask;
      rd_val[RDRV_SLP_BIT]   = rst_ctrl_q.drive_sleep;
      rd_val[RDLY_LSB +: 2]  = rst_ctrl_q.delay;
    end
    if (hit_sec) rd_val[0] = unlocked_q;
    if (hit_flag) rd_val[KEY_EVENT_BIT] = event_flag_q;
    if (hit_mask) rd_val[KEY_EVENT_BIT] = event_mask_q;
    if (hit_chg) rd_val[CHG_INH_BIT] = chg_inhibit_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= access & ~ack_q;
      if (rd_take) rdata_q <= {16'h0000, rd_val};
    end
  end
endmodule  // pkrp_top
`default_nettype wire

// ===== tb/pkrp_switch_model.sv
// user power switch and open-drain system reset line with pull-ups
`default_nettype none
module pkrp_switch_model (
  input  wire logic press,
  input  wire logic ext_low,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  output logic      key_pin_n,
  output logic      reset_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // switch shorts the pin to ground, pull-up otherwise
  assign key_pin_n = ~press;
  // any party pulling low wins over the pull-up
  assign reset_pin_in = ~((reset_pin_oe & ~reset_pin_out) | ext_low);
endmodule // pkrp_switch_model
`default_nettype wire

// ===== tb/pkrp_top_asserts.sv
// port-level assertions for the power key and reset pin block
`default_nettype none
module pkrp_top_asserts
  import pkrp_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES,
  parameter int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              key_pin_n,
  input wire logic              reset_pin_in,
  input wire logic              reset_pin_out,
  input wire logic              reset_pin_oe,
  input wire pkrp_pwr_t         pwr_state,
  input wire logic              pwr_up_done,
  input wire logic              charging,
  input wire pkrp_req_t         pwr_req,
  input wire logic              hw_reset_req,
  input wire logic              key_irq,
  input wire logic              on_ind,
  input wire logic              sleep_ind,
  input wire logic              aux_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  bus_wait_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  bus_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  on_ind_a: assert property (!$past(rst) |-> on_ind == ($past(pwr_state) == PWR_ON))
    else $error("on indicator wrong");
  sleep_ind_a: assert property (!$past(rst) |-> sleep_ind == ($past(pwr_state) == PWR_SLEEP))
    else $error("sleep indicator wrong");
  oe_off_a: assert property (pwr_state == PWR_OFF |=> reset_pin_oe)
    else $error("reset line released in off");
  oe_up_a: assert property (pwr_up_done |=> reset_pin_oe [*8])
    else $error("reset line released too early");
  drive_low_a: assert property (reset_pin_out == 1'b0)
    else $error("reset line driven high");
  aux_off_a: assert property (pwr_state == PWR_OFF |=> aux_reset)
    else $error("aux reset released in off");
  self_drv_a: assert property (hw_reset_req |->
    !$past(reset_pin_in) && !$past(reset_pin_oe))
    else $error("reset request without external low");
  hw_pulse_a: assert property (hw_reset_req |=> !hw_reset_req)
    else $error("reset request longer than one cycle");
  off_pulse_a: assert property (pwr_req.off_req |=> !pwr_req.off_req)
    else $error("off request longer than one cycle");

  on_req_c: cover property (pwr_req.on_req);
  off_req_c: cover property (pwr_req.off_req);
  hw_req_c: cover property (hw_reset_req);
endmodule // pkrp_top_asserts
`default_nettype wire

// ===== tb/pkrp_top_test.sv
// self-checking bench for the power key and reset pin block
`default_nettype none
module pkrp_top_test
  import pkrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  localparam logic [1:0] FIRST_EXP [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  localparam logic [1:0] HOLD_EXP [4]  = '{2'h0, 2'h2, 2'h1, 2'h0};
  logic              sys_clk        = 1'b0;
  logic              rst            = 1'b1;
  logic [ADDR_W-1:0] avs_address    = '0;
  logic              avs_read       = 1'b0;
  logic              avs_write      = 1'b0;
  logic [31:0]       avs_writedata  = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              key_pin_n;
  logic              reset_pin_in;
  logic              reset_pin_out;
  logic              reset_pin_oe;
  pkrp_pwr_t         pwr_state      = PWR_OFF;
  logic              pwr_up_done    = 1'b0;
  logic              charging       = 1'b0;
  pkrp_req_t         pwr_req;
  logic              hw_reset_req;
  logic              key_irq;
  logic              on_ind;
  logic              sleep_ind;
  logic              aux_reset;
  logic              press          = 1'b0;
  logic              ext_low        = 1'b0;
  logic [15:0]       rd;
  int                failures       = 0;
  int                checks         = 0;
  int                cyc            = 0;
  int                n;

  always #2 sys_clk = ~sys_clk;

  pkrp_top #(.MS_TICK_CYCLES(TICK), .DEBOUNCE_TICKS(2)) pkrp_top_inst (.*);
  pkrp_switch_model pkrp_switch_model_inst (.press(press), .ext_low(ext_low),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .key_pin_n(key_pin_n), .reset_pin_in(reset_pin_in));

  task automatic end_of_test();
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, wd};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask

  // sel 0 waits for a reset request, sel 1 for any power request
  task automatic waitsig(input int sel, input int lim);
    logic [1:0] hv;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      hv = {pwr_req != 2'h0, hw_reset_req};
    end while (n < lim && hv[sel] !== 1'b1);
  endtask

  task automatic keyrun(input logic [15:0] ctrl, input int lim, input logic [1:0] exp);
    bus(1'b1, IDX_KEY_CTRL, ctrl);
    @(posedge sys_clk);
    press <= 1'b1;
    waitsig(1, lim);
    chk({14'h0, pwr_req}, {14'h0, exp});
  endtask

  task automatic unpress();
    @(posedge sys_clk);
    press <= 1'b0;
    repeat (60) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rchk(IDX_KEY_CTRL, 16'h0108);
    rchk(IDX_RST_CTRL, 16'h0073);
    rchk(IDX_FLAGS_ONE, 16'h0000);
    rchk(IDX_MASK_ONE, 16'h1000);
    rchk(16'h4007, 16'h0000);
    bus(1'b1, IDX_KEY_CTRL, 16'h0210);
    rchk(IDX_KEY_CTRL, 16'h0108);
    bus(1'b1, IDX_SECURITY, USER_KEY_CODE);
    bus(1'b1, IDX_RST_CTRL, 16'h0040);
    bus(1'b1, IDX_MASK_ONE, 16'h0000);
    rchk(IDX_RST_CTRL, 16'h0040);
    chk({15'h0, reset_pin_oe}, 16'h0001);
    chk({15'h0, aux_reset}, 16'h0001);
    // power up, then the shortest release delay
    @(posedge sys_clk);
    pwr_state <= PWR_ON;
    pwr_up_done <= 1'b1;
    @(posedge sys_clk);
    pwr_up_done <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (reset_pin_oe === 1'b1 && n < 2000);
    chk({15'h0, n >= 2 * TICK && n <= 4 * TICK}, 16'h0001);
    chk({15'h0, on_ind}, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      keyrun({10'h0, c[1:0], 4'h0}, 100, FIRST_EXP[c]);
      rchk(IDX_KEY_CTRL, {10'h0, c[1:0], 4'h0});
      chk({15'h0, key_irq}, 16'h0001);
      bus(1'b1, IDX_FLAGS_ONE, 16'h1000);
      rchk(IDX_FLAGS_ONE, 16'h0000);
      unpress();
      rchk(IDX_FLAGS_ONE, 16'h1000);
      bus(1'b1, IDX_FLAGS_ONE, 16'h1000);
    end
    for (int c = 0; c < 4; c++) begin
      keyrun({6'h0, c[1:0], 8'h00}, 100, 2'h0);
      waitsig(1, 10100);
      chk({14'h0, pwr_req}, {14'h0, HOLD_EXP[c]});
      if (c == 2) begin
        chk({15'h0, n > 9800}, 16'h0001);
        waitsig(1, 10100);
        chk({14'h0, pwr_req}, 16'h0001);
        chk({15'h0, n > 9900}, 16'h0001);
      end
      unpress();
    end
    rchk(IDX_FLAGS_ONE, 16'h1000);
    bus(1'b1, IDX_MASK_ONE, 16'h1000);
    @(negedge sys_clk);
    chk({15'h0, key_irq}, 16'h0000);
    bus(1'b1, IDX_CHG_CTRL, 16'h0001);
    charging <= 1'b1;
    keyrun(16'h0020, 300, 2'h0);
    unpress();
    charging <= 1'b0;
    // sleep with the line released, external low taken as reset
    pwr_state <= PWR_SLEEP;
    repeat (3) @(posedge sys_clk);
    chk({13'h0, sleep_ind, on_ind, reset_pin_oe}, 16'h0004);
    chk({15'h0, aux_reset}, 16'h0001);
    ext_low <= 1'b1;
    waitsig(0, 10);
    chk({15'h0, hw_reset_req}, 16'h0001);
    @(posedge sys_clk);
    ext_low <= 1'b0;
    rchk(IDX_KEY_CTRL, 16'h0108);
    rchk(IDX_RST_CTRL, 16'h0073);
    chk({15'h0, reset_pin_oe}, 16'h0001);
    bus(1'b1, IDX_SECURITY, USER_KEY_CODE);
    bus(1'b1, IDX_RST_CTRL, 16'h0060);
    repeat (3) @(posedge sys_clk);
    chk({15'h0, reset_pin_oe}, 16'h0000);
    ext_low <= 1'b1;
    waitsig(0, 10);
    chk({15'h0, hw_reset_req}, 16'h0000);
    @(posedge sys_clk);
    ext_low <= 1'b0;
    pwr_state <= PWR_OFF;
    waitsig(0, 10);
    chk({15'h0, hw_reset_req}, 16'h0000);
    chk({15'h0, reset_pin_in}, 16'h0000);
    chk({14'h0, reset_pin_oe, aux_reset}, 16'h0003);
    end_of_test();
  end
endmodule // pkrp_top_test

bind pkrp_top pkrp_top_asserts #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
  .DEBOUNCE_TICKS(DEBOUNCE_TICKS)) pkrp_top_asserts_inst (.*);
`default_nettype wire
